// ---- hw/charge_cfg_pkg.sv ----
// Constants and types for the charge target and termination register bank.
// Assumes a single 10 MHz clock and a 16-bit word register port.
package charge_cfg_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CC_TARGET_ADDR  = 8'h1a;
  localparam logic [7:0] CV_TARGET_ADDR  = 8'h1b;
  localparam logic [7:0] LOW_CUR_ADDR    = 8'h1c;
  localparam logic [7:0] CV_LIMIT_ADDR   = 8'h1d;
  localparam logic [7:0] TOT_LIMIT_ADDR  = 8'h1e;
  localparam logic [7:0] TEMP_B1_ADDR    = 8'h1f;
  localparam logic [7:0] TEMP_B2_ADDR    = 8'h20;
  localparam logic [7:0] TEMP_B3_ADDR    = 8'h21;

  // ----------------------------------------------------------------------
  // Reset values and field widths
  // ----------------------------------------------------------------------
  localparam int          CODE_W          = 5;
  localparam logic [4:0]  CC_TARGET_RST   = 5'h1f;
  localparam logic [4:0]  CV_TARGET_RST   = 5'h1f;
  localparam logic [15:0] LOW_CUR_RST     = 16'h0888;
  localparam logic [15:0] CV_LIMIT_RST    = 16'h3840;
  localparam logic [15:0] CV_LIMIT_HALF_HR = 16'h0708;
  localparam logic [15:0] TOT_LIMIT_RST   = 16'h0000;
  localparam logic [15:0] TEMP_B1_RST     = 16'h3ef5;
  localparam logic [15:0] TEMP_B2_RST     = 16'h3721;
  localparam logic [15:0] TEMP_B3_RST     = 16'h1f22;
  localparam logic [4:0]  RAMP_FULL       = 5'h1f;
  localparam logic [4:0]  RAMP_MIN        = 5'h00;

  // ----------------------------------------------------------------------
  // Voltage scaling in units of 0.5 mV
  // ----------------------------------------------------------------------
  localparam logic [16:0] VSTEP_HALF_MV   = 17'h00019;
  localparam logic [16:0] VBASE_HALF_MV   = 17'h01dc9;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          SEC_TIME_S      = 1;
  localparam int          SEC_CYCLES      = SEC_TIME_S * CLK_HZ;
  localparam logic [5:0]  MIN_SECS        = 6'h3c;

  typedef struct packed {
    logic [4:0]  cc_target;
    logic [4:0]  cv_target;
    logic [15:0] low_cur;
    logic [15:0] cv_limit;
    logic [15:0] tot_limit;
    logic [15:0] temp_b1;
    logic [15:0] temp_b2;
    logic [15:0] temp_b3;
  } cfg_regs_t;

  localparam cfg_regs_t CFG_RST = '{
    cc_target: CC_TARGET_RST, cv_target: CV_TARGET_RST, low_cur: LOW_CUR_RST,
    cv_limit: CV_LIMIT_RST, tot_limit: TOT_LIMIT_RST, temp_b1: TEMP_B1_RST,
    temp_b2: TEMP_B2_RST, temp_b3: TEMP_B3_RST};

endpackage : charge_cfg_pkg

// ---- hw/phase_timer.sv ----
// Tick-driven elapsed timer with a limit compare.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/1ns
module phase_timer
  import charge_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic [15:0] limit,
  output logic      [15:0] count_ff,
  output logic             expired_ff
);

  logic [15:0] nxt_count;
  logic        nxt_expired;

  // ----------------------------------------------------------------------
  // Count and compare
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    if (!run || !enable) begin
      nxt_count = 16'h0000;
    end else if (tick && count_ff != 16'hffff) begin
      nxt_count = count_ff + 16'h0001;
    end
    nxt_expired = enable && run && (count_ff >= limit);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_ff   <= 16'h0000;
      expired_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

endmodule : phase_timer

// ---- hw/charge_target_and_termination_regs.sv ----
// Charge target and termination register bank with applied levels.
// Assumes telemetry and charger state inputs on sys_clk; word register port.
//
// Behaviour
// - Current servo is (code + 1) mV, reset 31
// - Applied current follows code unless capped/overridden
// - Charge voltage: cells times (code*12.5mV+3.8125V)
// - Applied voltage follows code unless temperature override
// - Signed current compared to signed threshold
// - CV timer counts seconds from CV phase
// - Zero total limit clears timer to zero; else minutes
// - Three signed temperature boundaries define regions
// - Die temperature ramps current cap 31 to 0
`timescale 1ns/1ns
module charge_target_and_termination_regs
  import charge_cfg_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_ff,
  input  wire logic        temp_ctl_active,
  input  wire logic [4:0]  temp_ctl_current,
  input  wire logic [4:0]  temp_ctl_voltage,
  input  wire logic [15:0] die_temp,
  input  wire logic [15:0] thermal_start_temp,
  input  wire logic [15:0] thermal_end_temp,
  input  wire logic [3:0]  cell_count,
  input  wire logic [15:0] ibat_meas,
  input  wire logic [15:0] thermistor_meas,
  input  wire logic        cv_phase,
  input  wire logic        charge_cycle,
  output logic      [4:0]  icharge_level_ff,
  output logic      [4:0]  vcharge_level_ff,
  output logic      [5:0]  cc_servo_mv_ff,
  output logic      [16:0] charge_volt_ff,
  output logic             low_current_ff,
  output logic      [2:0]  temp_region_ff,
  output logic      [15:0] cv_time_ff,
  output logic             cv_timeout_ff,
  output logic      [15:0] tot_time_ff,
  output logic             tot_timeout_ff
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [4:0] ramp_cap(input logic signed [15:0] die,
                                          input logic signed [15:0] t_start,
                                          input logic signed [15:0] t_end);
    int span;
    int num;
    span = int'(t_end) - int'(t_start);
    num  = 0;
    if (die <= t_start) begin
      ramp_cap = RAMP_FULL;
    end else if (die >= t_end || span <= 0) begin
      ramp_cap = RAMP_MIN;
    end else begin
      num      = (int'(t_end) - int'(die)) * int'(RAMP_FULL);
      ramp_cap = 5'(num / span);
    end
  endfunction : ramp_cap

  function automatic logic [16:0] volt_of(input logic [4:0] code,
                                          input logic [3:0] cells);
    logic [16:0] per_cell;
    per_cell = 17'(code) * VSTEP_HALF_MV + VBASE_HALF_MV;
    volt_of  = 17'(per_cell * 17'(cells));
  endfunction : volt_of

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  cfg_regs_t   cfg_ff;
  cfg_regs_t   nxt_cfg;
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        CC_TARGET_ADDR: nxt_cfg.cc_target = reg_wdata[4:0];
        CV_TARGET_ADDR: nxt_cfg.cv_target = reg_wdata[4:0];
        LOW_CUR_ADDR:   nxt_cfg.low_cur   = reg_wdata;
        CV_LIMIT_ADDR:  nxt_cfg.cv_limit  = reg_wdata;
        TOT_LIMIT_ADDR: nxt_cfg.tot_limit = reg_wdata;
        TEMP_B1_ADDR:   nxt_cfg.temp_b1   = reg_wdata;
        TEMP_B2_ADDR:   nxt_cfg.temp_b2   = reg_wdata;
        TEMP_B3_ADDR:   nxt_cfg.temp_b3   = reg_wdata;
        default:        nxt_cfg = cfg_ff;
      endcase
    end
    nxt_rdata = reg_rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        CC_TARGET_ADDR: nxt_rdata = {11'h000, cfg_ff.cc_target};
        CV_TARGET_ADDR: nxt_rdata = {11'h000, cfg_ff.cv_target};
        LOW_CUR_ADDR:   nxt_rdata = cfg_ff.low_cur;
        CV_LIMIT_ADDR:  nxt_rdata = cfg_ff.cv_limit;
        TOT_LIMIT_ADDR: nxt_rdata = cfg_ff.tot_limit;
        TEMP_B1_ADDR:   nxt_rdata = cfg_ff.temp_b1;
        TEMP_B2_ADDR:   nxt_rdata = cfg_ff.temp_b2;
        TEMP_B3_ADDR:   nxt_rdata = cfg_ff.temp_b3;
        default:        nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_ff       <= CFG_RST;
      reg_rdata_ff <= 16'h0000;
    end else begin
      cfg_ff       <= nxt_cfg;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Applied levels and compares
  // ----------------------------------------------------------------------
  logic [4:0]  cap;
  logic [4:0]  i_src;
  logic [4:0]  nxt_icharge;
  logic [4:0]  nxt_vcharge;
  logic [5:0]  nxt_servo;
  logic [16:0] nxt_volt;
  logic        nxt_low;
  logic [2:0]  nxt_region;

  always_comb begin
    cap         = ramp_cap(die_temp, thermal_start_temp, thermal_end_temp);
    i_src       = temp_ctl_active ? temp_ctl_current : cfg_ff.cc_target;
    nxt_icharge = (i_src > cap) ? cap : i_src;
    nxt_vcharge = temp_ctl_active ? temp_ctl_voltage : cfg_ff.cv_target;
    nxt_servo   = {1'b0, nxt_icharge} + 6'h01;
    nxt_volt    = volt_of(nxt_vcharge, cell_count);
    nxt_low     = $signed(ibat_meas) < $signed(cfg_ff.low_cur);
    if ($signed(thermistor_meas) > $signed(cfg_ff.temp_b1)) begin
      nxt_region = 3'h1;
    end else if ($signed(thermistor_meas) > $signed(cfg_ff.temp_b2)) begin
      nxt_region = 3'h2;
    end else if ($signed(thermistor_meas) > $signed(cfg_ff.temp_b3)) begin
      nxt_region = 3'h3;
    end else begin
      nxt_region = 3'h4;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      icharge_level_ff <= CC_TARGET_RST;
      vcharge_level_ff <= CV_TARGET_RST;
      cc_servo_mv_ff   <= 6'h00;
      charge_volt_ff   <= 17'h00000;
      low_current_ff   <= 1'b0;
      temp_region_ff   <= 3'h1;
    end else begin
      icharge_level_ff <= nxt_icharge;
      vcharge_level_ff <= nxt_vcharge;
      cc_servo_mv_ff   <= nxt_servo;
      charge_volt_ff   <= nxt_volt;
      low_current_ff   <= nxt_low;
      temp_region_ff   <= nxt_region;
    end
  end

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  logic [23:0] sec_div_ff;
  logic [23:0] nxt_sec_div;
  logic [5:0]  min_div_ff;
  logic [5:0]  nxt_min_div;
  logic        sec_tick_ff;
  logic        nxt_sec_tick;
  logic        min_tick_ff;
  logic        nxt_min_tick;

  always_comb begin
    nxt_sec_tick = (sec_div_ff == 24'(SEC_CYCLES_P - 1));
    nxt_sec_div  = nxt_sec_tick ? 24'h000000 : sec_div_ff + 24'h000001;
    nxt_min_tick = 1'b0;
    nxt_min_div  = min_div_ff;
    if (sec_tick_ff) begin
      nxt_min_tick = (min_div_ff == MIN_SECS - 6'h01);
      nxt_min_div  = nxt_min_tick ? 6'h00 : min_div_ff + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sec_div_ff  <= 24'h000000;
      min_div_ff  <= 6'h00;
      sec_tick_ff <= 1'b0;
      min_tick_ff <= 1'b0;
    end else begin
      sec_div_ff  <= nxt_sec_div;
      min_div_ff  <= nxt_min_div;
      sec_tick_ff <= nxt_sec_tick;
      min_tick_ff <= nxt_min_tick;
    end
  end

  // ----------------------------------------------------------------------
  // Termination timers
  // ----------------------------------------------------------------------
  phase_timer u_cv_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .run        (cv_phase),
    .tick       (sec_tick_ff),
    .enable     (1'b1),
    .limit      (cfg_ff.cv_limit),
    .count_ff   (cv_time_ff),
    .expired_ff (cv_timeout_ff)
  );

  phase_timer u_tot_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .run        (charge_cycle),
    .tick       (min_tick_ff),
    .enable     (cfg_ff.tot_limit != 16'h0000),
    .limit      (cfg_ff.tot_limit),
    .count_ff   (tot_time_ff),
    .expired_ff (tot_timeout_ff)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_servo_offset: assert property (
    !$past(srst) |-> cc_servo_mv_ff == {1'b0, icharge_level_ff} + 6'h01)
    else $error("servo level not code plus one");
  a_icharge_follow: assert property (
    (!temp_ctl_active && $signed(die_temp) <= $signed(thermal_start_temp))
      |=> icharge_level_ff == $past(cfg_ff.cc_target))
    else $error("applied current does not follow code");
  a_voltage_scale: assert property (
    (cell_count == 4'h1 && !temp_ctl_active && cfg_ff.cv_target == 5'h1f)
      |=> charge_volt_ff == 17'h020d0)
    else $error("charge voltage scaling wrong");
  a_vcharge_sel: assert property (
    temp_ctl_active |=> vcharge_level_ff == $past(temp_ctl_voltage))
    else $error("voltage override not applied");
  a_low_compare: assert property (
    ($signed(ibat_meas) >= $signed(cfg_ff.low_cur)) |=> !low_current_ff)
    else $error("low current flag wrong");
  a_cv_restart: assert property (
    !cv_phase |=> cv_time_ff == 16'h0000 && !cv_timeout_ff)
    else $error("cv timer not held outside cv phase");
  a_tot_disabled: assert property (
    (cfg_ff.tot_limit == 16'h0000) [*2] |-> tot_time_ff == 16'h0000 && !tot_timeout_ff)
    else $error("total timer runs while disabled");
  a_region_cold: assert property (
    ($signed(thermistor_meas) > $signed(cfg_ff.temp_b1)) |=> temp_region_ff == 3'h1)
    else $error("cold region not reported");
  a_ramp_hot: assert property (
    ($signed(die_temp) >= $signed(thermal_end_temp)) |=> icharge_level_ff == RAMP_MIN)
    else $error("current not capped at hot end");
  a_unmapped_zero: assert property (
    (reg_rd && (reg_addr < CC_TARGET_ADDR || reg_addr > TEMP_B3_ADDR))
      |=> reg_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  a_write_readback: assert property (
    (reg_wr && reg_addr == LOW_CUR_ADDR) ##1 (reg_rd && reg_addr == LOW_CUR_ADDR && !reg_wr)
      |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("write readback mismatch");

  c_cv_timeout:  cover property (cv_phase ##1 cv_timeout_ff);
  c_tot_timeout: cover property (tot_timeout_ff);
  c_region_four: cover property (temp_region_ff == 3'h4);
  c_ramp_mid:    cover property (icharge_level_ff > RAMP_MIN && icharge_level_ff < RAMP_FULL);

endmodule : charge_target_and_termination_regs

// ---- verification/charge_host_model.sv ----
// Host controller model driving the word register port of the charge bank.
// Assumes the bank samples strobes on the rising edge of sys_clk.
`timescale 1ns/1ns
module charge_host_model
  import charge_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata
);
  // ----------------------------------------------------------------
  // Word accesses, one strobe cycle each
  // ----------------------------------------------------------------
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // Write then read the same word on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr_rd

  // Boundaries are handed over coldest first, highest value; nothing is written unless strictly descending
  task automatic bounds(input logic [15:0] b1, input logic [15:0] b2, input logic [15:0] b3);
    if ($signed(b1) > $signed(b2) && $signed(b2) > $signed(b3)) begin
      wr(TEMP_B1_ADDR, b1);
      wr(TEMP_B2_ADDR, b2);
      wr(TEMP_B3_ADDR, b3);
    end
  endtask : bounds
endmodule : charge_host_model

// ---- verification/charge_target_and_termination_regs_tb.sv ----
// Self-checking bench for the charge target and termination register bank.
// Assumes a shortened second of 10 cycles; host model drives the port.
`timescale 1ns/1ns
module charge_target_and_termination_regs_tb;
  import charge_cfg_pkg::*;
  logic        sys_clk, srst, reg_wr, reg_rd, temp_ctl_active, cv_phase, charge_cycle;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata_ff, die_temp, thermal_start_temp, thermal_end_temp;
  logic [15:0] ibat_meas, thermistor_meas, cv_time_ff, tot_time_ff, v;
  logic [4:0]  temp_ctl_current, temp_ctl_voltage, icharge_level_ff, vcharge_level_ff, c;
  logic [3:0]  cell_count;
  logic [5:0]  cc_servo_mv_ff;
  logic [16:0] charge_volt_ff;
  logic        low_current_ff, cv_timeout_ff, tot_timeout_ff, pend;
  logic [2:0]  temp_region_ff;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int          n_fail, total_checks, cyc, i;
  logic [7:0]  at[8] = '{CC_TARGET_ADDR, CV_TARGET_ADDR, LOW_CUR_ADDR, CV_LIMIT_ADDR,
                         TOT_LIMIT_ADDR, TEMP_B1_ADDR, TEMP_B2_ADDR, TEMP_B3_ADDR};
  logic [15:0] rt[8] = '{{11'h0, CC_TARGET_RST}, {11'h0, CV_TARGET_RST}, LOW_CUR_RST,
                         CV_LIMIT_RST, TOT_LIMIT_RST, TEMP_B1_RST, TEMP_B2_RST, TEMP_B3_RST};
  logic [15:0] tv[5] = '{16'd16118, 16'd16117, 16'd14113, 16'd7971, 16'd7970};
  logic [2:0]  te[5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};

  charge_target_and_termination_regs #(.SEC_CYCLES_P(10)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .temp_ctl_active(temp_ctl_active),
    .temp_ctl_current(temp_ctl_current), .temp_ctl_voltage(temp_ctl_voltage),
    .die_temp(die_temp), .thermal_start_temp(thermal_start_temp),
    .thermal_end_temp(thermal_end_temp), .cell_count(cell_count), .ibat_meas(ibat_meas),
    .thermistor_meas(thermistor_meas), .cv_phase(cv_phase), .charge_cycle(charge_cycle),
    .icharge_level_ff(icharge_level_ff), .vcharge_level_ff(vcharge_level_ff),
    .cc_servo_mv_ff(cc_servo_mv_ff), .charge_volt_ff(charge_volt_ff),
    .low_current_ff(low_current_ff), .temp_region_ff(temp_region_ff),
    .cv_time_ff(cv_time_ff), .cv_timeout_ff(cv_timeout_ff), .tot_time_ff(tot_time_ff),
    .tot_timeout_ff(tot_timeout_ff));
  charge_host_model u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
                            .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  task automatic cmp(input logic [16:0] g, input logic [16:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t output %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic cmp_rd(input logic [15:0] e);
    total_checks++;
    if (reg_rdata_ff !== e) begin
      n_fail++;
      $display("ERROR %0t read %h exp %h", $time, reg_rdata_ff, e);
    end
  endtask : cmp_rd

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Read results land one cycle after the strobe edge
  always @(posedge sys_clk) begin
    if (pend) cmp_rd(exp_q.pop_front());
    pend = reg_rd;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, pend, seed} = {2'b10, 32'hf89eca81};
    {temp_ctl_active, cv_phase, charge_cycle, temp_ctl_current, temp_ctl_voltage} = '0;
    {die_temp, thermal_start_temp, thermal_end_temp} = {16'd0, 16'd100, 16'd200};
    {ibat_meas, thermistor_meas, cell_count} = {16'd0, 16'd16000, 4'h1};
    repeat (10) @(posedge sys_clk);
    #1 srst = 1'b0;
    for (i = 0; i < 8; i++) rd(at[i], rt[i]);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      u_host.wr(at[i], seed[15:0]);
      rd(at[i], i < 2 ? {11'h0, seed[4:0]} : seed[15:0]);
    end
    u_host.wr(8'h22, seed[15:0]);
    rd(8'h22, 16'h0000);
    seed = lfsr(seed);
    exp_q.push_back(seed[15:0]);
    u_host.wr_rd(LOW_CUR_ADDR, seed[15:0]);
    u_host.wr(CV_LIMIT_ADDR, CV_LIMIT_HALF_HR);
    rd(CV_LIMIT_ADDR, 16'd1800);
    seed = lfsr(seed);
    c = seed[4:0];
    v = {11'h0, ~c};
    cell_count = {1'b0, seed[18:16]} + 4'h1;
    u_host.wr(CC_TARGET_ADDR, {11'h0, c});
    u_host.wr(CV_TARGET_ADDR, v);
    settle();
    cmp(17'(icharge_level_ff), 17'(c));
    cmp(17'(cc_servo_mv_ff), 17'(c) + 17'd1);
    cmp(17'(vcharge_level_ff), 17'(v));
    cmp(charge_volt_ff, 17'(int'(cell_count) * (int'(v) * 25 + 7625)));
    {temp_ctl_active, temp_ctl_current, temp_ctl_voltage} = {1'b1, 5'h07, 5'h13};
    settle();
    cmp(17'(icharge_level_ff), 17'h7);
    cmp(17'(cc_servo_mv_ff), 17'h8);
    cmp(17'(vcharge_level_ff), 17'h13);
    temp_ctl_active = 1'b0;
    u_host.wr(CC_TARGET_ADDR, 16'h001f);
    {thermal_start_temp, thermal_end_temp, die_temp} = {16'd0, 16'd62, 16'd31};
    settle();
    cmp(17'(icharge_level_ff), 17'd15);
    die_temp = 16'd62;
    settle();
    cmp(17'(icharge_level_ff), 17'd0);
    die_temp = 16'hfffb;
    settle();
    cmp(17'(icharge_level_ff), 17'd31);
    u_host.wr(LOW_CUR_ADDR, 16'hfff0);
    ibat_meas = 16'hffef;
    settle();
    cmp(17'(low_current_ff), 17'h1);
    ibat_meas = 16'hfff0;
    settle();
    cmp(17'(low_current_ff), 17'h0);
    u_host.bounds(TEMP_B1_RST, TEMP_B2_RST, TEMP_B3_RST);
    for (i = 0; i < 5; i++) begin
      thermistor_meas = tv[i];
      settle();
      cmp(17'(temp_region_ff), 17'(te[i]));
    end
    u_host.wr(CV_LIMIT_ADDR, 16'h0003);
    cv_phase = 1'b1;
    for (i = 0; i < 45 && cv_timeout_ff !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    cmp(17'(cv_timeout_ff), 17'h1);
    cmp(17'(cv_time_ff), 17'h3);
    cv_phase = 1'b0;
    settle();
    cmp(17'(cv_time_ff), 17'h0);
    charge_cycle = 1'b1;
    u_host.wr(TOT_LIMIT_ADDR, 16'h0000);
    repeat (700) @(posedge sys_clk);
    #1 cmp(17'({tot_timeout_ff, tot_time_ff}), 17'h0);
    u_host.wr(TOT_LIMIT_ADDR, 16'h0001);
    for (i = 0; i < 1300 && tot_timeout_ff !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    cmp(17'({tot_timeout_ff, tot_time_ff}), 17'h10001);
    u_host.wr(TOT_LIMIT_ADDR, 16'h0000);
    settle();
    cmp(17'({tot_timeout_ff, tot_time_ff}), 17'h0);
    results();
  end
endmodule : charge_target_and_termination_regs_tb
